// ### inc/gpp_pkg.sv
// constants, types and helpers shared by the gpio port control block
package gpp_pkg;

   localparam int NPIN = 32;
   localparam int NREG = 9;

   // ************************************************************
   // register byte offsets
   // ************************************************************
   localparam logic [8:0] OFS_OUTPUT_VALUE  = 9'h050;
   localparam logic [8:0] OFS_PIN_LEVEL     = 9'h060;
   localparam logic [8:0] OFS_PULLUP        = 9'h070;
   localparam logic [8:0] OFS_PULLDOWN      = 9'h080;
   localparam logic [8:0] OFS_IRQ_ENABLE    = 9'h090;
   localparam logic [8:0] OFS_IRQ_MODE_LO   = 9'h0A0;
   localparam logic [8:0] OFS_IRQ_MODE_HI   = 9'h0B0;
   localparam logic [8:0] OFS_GLITCH_EN     = 9'h0C0;
   localparam logic [8:0] OFS_IRQ_FLAGS     = 9'h0D0;
   localparam logic [8:0] OFS_IRQ_FLAGS_CLR = 9'h0D8;
   localparam logic [8:0] OFS_DRIVE_LO      = 9'h100;
   localparam logic [8:0] OFS_DRIVE_HI      = 9'h110;
   localparam logic [8:0] OFS_LOCK          = 9'h1A0;
   localparam logic [8:0] OFS_LOCK_SET      = 9'h1A4;
   localparam logic [8:0] OFS_UNLOCK        = 9'h1E0;
   localparam logic [8:0] OFS_ACCESS_STATUS = 9'h1E4;

   // ************************************************************
   // fields and reset values
   // ************************************************************
   localparam logic [7:0]      UNLOCK_KEY  = 8'hAA;
   localparam int              KEY_MSB     = 31;
   localparam int              KEY_LSB     = 24;
   localparam int              TGT_MSB     = 9;
   localparam int              AE_BIT      = 0;
   localparam logic [NPIN-1:0] CFG_RESET   = 32'h0000_0000;

   // lockable registers, index into the config array
   localparam int R_OVR  = 0;
   localparam int R_PU   = 1;
   localparam int R_PD   = 2;
   localparam int R_IER  = 3;
   localparam int R_ML   = 4;
   localparam int R_MH   = 5;
   localparam int R_GFE  = 6;
   localparam int R_DSL  = 7;
   localparam int R_DSH  = 8;
   localparam logic [8:0] REG_BASE [NREG] = '{
      OFS_OUTPUT_VALUE, OFS_PULLUP, OFS_PULLDOWN, OFS_IRQ_ENABLE,
      OFS_IRQ_MODE_LO, OFS_IRQ_MODE_HI, OFS_GLITCH_EN,
      OFS_DRIVE_LO, OFS_DRIVE_HI};

   typedef enum logic [3:0] {
      OP_WRITE = 4'h1,
      OP_SET   = 4'h2,
      OP_CLEAR = 4'h4,
      OP_TOGGLE = 4'h8
   } gpp_op_type;

   typedef struct packed {
      logic [NPIN-1:0] out;
      logic [NPIN-1:0] pull_up;
      logic [NPIN-1:0] pull_down;
      logic [NPIN-1:0] keeper;
      logic [NPIN-1:0] drive_lo;
      logic [NPIN-1:0] drive_hi;
   } gpp_pad_type;

   // alias word within a four-word register group
   function automatic gpp_op_type alias_op(input logic [1:0] sel);
      case (sel)
         2'h1:    alias_op = OP_SET;
         2'h2:    alias_op = OP_CLEAR;
         2'h3:    alias_op = OP_TOGGLE;
         default: alias_op = OP_WRITE;
      endcase
   endfunction

   // address falls in the four-word group starting at base
   function automatic logic grp_hit(input logic [8:0] a,
                                    input logic [8:0] base);
      grp_hit = (a[8:4] == base[8:4]);
   endfunction

endpackage

// ### core/gpp_sct_reg.sv
// one 32-bit register with write, set, clear and toggle aliases
`timescale 1ns/1ps
`default_nettype none
module gpp_sct_reg
   import gpp_pkg::*;
#(
   parameter int             W   = NPIN,
   parameter logic [W-1:0]   RST = '0
)(
   // clock and reset
   input  wire logic         mclk,
   input  wire logic         resetn,
   // access
   input  wire logic         en,
   input  var  gpp_op_type   op,
   input  wire logic [W-1:0] wdata,
   input  wire logic [W-1:0] lock_mask,
   // state
   output logic [W-1:0]      q,
   output logic              locked_hit
);

   logic [W-1:0] q_reg;
   logic [W-1:0] raw_next;
   logic [W-1:0] q_next;

   assign raw_next = (op == OP_SET)    ? (q_reg | wdata)  :
                     (op == OP_CLEAR)  ? (q_reg & ~wdata) :
                     (op == OP_TOGGLE) ? (q_reg ^ wdata)  : wdata;
   // locked bits keep their value
   assign q_next = (raw_next & ~lock_mask) | (q_reg & lock_mask);
   assign locked_hit = en & (|((raw_next ^ q_reg) & lock_mask));
   assign q = q_reg;

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         q_reg <= RST;
      else if (en)
         q_reg <= q_next;
   end

endmodule
`default_nettype wire

// ### core/gpp_in_filter.sv
// pad input synchroniser with selectable two-sample glitch filter
`timescale 1ns/1ps
`default_nettype none
module gpp_in_filter
   import gpp_pkg::*;
#(
   parameter int W = NPIN
)(
   // clock and reset
   input  wire logic         mclk,
   input  wire logic         resetn,
   // pads and control
   input  wire logic [W-1:0] pad_in,
   input  wire logic [W-1:0] filt_en,
   // synchronised levels
   output logic [W-1:0]      sync_level,
   output logic [W-1:0]      level
);

   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;
   logic [W-1:0] filt_reg;
   logic [W-1:0] filt_next;

   // output follows only two equal successive samples
   assign filt_next = (s2_reg & s3_reg) | (filt_reg & (s2_reg | s3_reg));
   assign sync_level = s2_reg;
   assign level = (filt_en & filt_reg) | (~filt_en & s2_reg);

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         s1_reg   <= '0;
         s2_reg   <= '0;
         s3_reg   <= '0;
         filt_reg <= '0;
      end
      else
      begin
         s1_reg   <= pad_in;
         s2_reg   <= s1_reg;
         s3_reg   <= s2_reg;
         filt_reg <= filt_next;
      end
   end

endmodule
`default_nettype wire

// ### core/gpp_port_ctrl.sv
// per-pin control, status, interrupt flags and locking of one gpio port
//
// Summary of operation
// RULE_01: each pin drives the level held in its output value bit.
// RULE_02: read-only pin level register reports sampled pad levels.
// RULE_03: pin level is real only under gpio control or interrupt enable.
// RULE_04: one pull-up enable bit per pin, one enables, zero disables.
// RULE_05: pull-up/pull-down pair: 00 none, 01 down, 10 up, 11 keeper.
// RULE_06: per-pin interrupt enable; zero blocks that pin's requests.
// RULE_07: mode pair: 00 any change, 01 rising, 10 falling, 11 reserved.
// RULE_08: per-pin glitch filter enable; filter sits before edge detection.
// RULE_09: software changes glitch filter only while the pin's interrupt is off.
// RULE_10: detected trigger sets the flag; read one offset, clear another.
// RULE_11: a flag counts only while that pin's interrupt enable is one.
// RULE_12: drive strength pair: 00 weakest up to 11 strongest.
// RULE_13: a locked pin's bit cannot change in any lockable register.
// RULE_14: lock write, clear, toggle need the unlock write just before.
// RULE_15: lock set alias is never protected.
// RULE_16: each control register has write, set, clear, toggle words.
// RULE_17: unlock takes effect only with the correct key.
// RULE_18: unlock target offset includes the port offset.
// RULE_19: writing a locked register sets the access error bit.
// RULE_20: set, clear, toggle act on ones; zeros and locked bits untouched.
// RULE_21: edges from synchronised input versus previous sample; reserved silent.
`timescale 1ns/1ps
`default_nettype none
module gpp_port_ctrl
   import gpp_pkg::*;
#(
   parameter logic [TGT_MSB:0] PORT_OFFSET = 10'h000
)(
   // clock and reset
   input  wire logic            mclk,
   input  wire logic            resetn,
   // register port
   input  wire logic [8:0]      bus_addr,
   input  wire logic [31:0]     bus_wdata,
   input  wire logic            bus_wr,
   input  wire logic            bus_rd,
   output logic [31:0]          bus_rdata,
   // pins
   input  wire logic [NPIN-1:0] pad_in,
   input  wire logic [NPIN-1:0] gp_select,
   output gpp_pad_type          pad_o,
   output logic [NPIN-1:0]      pin_irq
);

   // ************************************************************
   // declarations
   // ************************************************************
   logic [NPIN-1:0]  cfg_q [NREG];
   logic [NREG-1:0]  hit_vec;
   logic [NPIN-1:0]  lock_q;
   logic [NPIN-1:0]  sync_level;
   logic [NPIN-1:0]  in_level;
   logic [NPIN-1:0]  prev_reg;
   logic [NPIN-1:0]  flags_reg;
   logic [NPIN-1:0]  flags_next;
   logic [NPIN-1:0]  level_reg;
   logic [NPIN-1:0]  irq_reg;
   logic [31:0]      rdata_reg;
   logic [31:0]      rd_next;
   logic             armed_reg;
   logic             armed_next;
   logic [TGT_MSB:0] target_reg;
   logic             ae_reg;
   logic             ae_next;
   gpp_pad_type      pad_reg;
   gpp_pad_type      pad_next;

   // ************************************************************
   // address decode
   // ************************************************************
   wire gpp_op_type       op_sel = alias_op(bus_addr[3:2]);
   wire logic [TGT_MSB:0] full_ofs = PORT_OFFSET + 10'(bus_addr);
   wire logic             lock_grp = grp_hit(bus_addr, OFS_LOCK);
   wire logic             lock_set_wr = bus_wr && bus_addr == OFS_LOCK_SET;
   wire logic             lock_prot_wr = bus_wr && lock_grp && !lock_set_wr;
   wire logic             unlock_wr = bus_wr && bus_addr == OFS_UNLOCK &&
                    bus_wdata[KEY_MSB:KEY_LSB] == UNLOCK_KEY; // [RULE_17]
   wire logic             lock_granted = lock_prot_wr && armed_reg &&
                    target_reg == full_ofs; // [RULE_14] [RULE_18]
   wire logic             flag_clr_wr = bus_wr &&
                    bus_addr == OFS_IRQ_FLAGS_CLR;
   wire logic             asr_wr = bus_wr && bus_addr == OFS_ACCESS_STATUS;

   // ************************************************************
   // lockable control registers
   // ************************************************************
   for (genvar g = 0; g < NREG; g++)
   begin : g_cfg
      gpp_sct_reg #(
         .W         (NPIN),
         .RST       (CFG_RESET)
      ) u_reg (
         .mclk      (mclk),
         .resetn    (resetn),
         .en        (bus_wr && grp_hit(bus_addr, REG_BASE[g])), // [RULE_16]
         .op        (op_sel), // [RULE_20]
         .wdata     (bus_wdata),
         .lock_mask (lock_q), // [RULE_13]
         .q         (cfg_q[g]),
         .locked_hit(hit_vec[g])
      );
   end

   // lock register: set alias open, the others need unlock
   gpp_sct_reg #(
      .W         (NPIN),
      .RST       (CFG_RESET)
   ) u_lock (
      .mclk      (mclk),
      .resetn    (resetn),
      .en        (lock_granted || lock_set_wr), // [RULE_15]
      .op        (op_sel),
      .wdata     (bus_wdata),
      .lock_mask ('0),
      .q         (lock_q),
      .locked_hit()
   );

   // ************************************************************
   // unlock sequencing and access error
   // ************************************************************
   // armed only for the very next write
   assign armed_next = bus_wr ? unlock_wr : armed_reg; // [RULE_14]
   // set wins over software clear
   assign ae_next = (|hit_vec) || (lock_prot_wr && !lock_granted) ||
                    (ae_reg && !(asr_wr && !bus_wdata[AE_BIT])); // [RULE_19]

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         armed_reg  <= 1'b0;
         target_reg <= '0;
         ae_reg     <= 1'b0;
      end
      else
      begin
         armed_reg <= armed_next;
         ae_reg    <= ae_next;
         if (unlock_wr)
            target_reg <= bus_wdata[TGT_MSB:0];
      end
   end

   // ************************************************************
   // input path and interrupt flags
   // ************************************************************
   gpp_in_filter #(
      .W         (NPIN)
   ) u_flt (
      .mclk      (mclk),
      .resetn    (resetn),
      .pad_in    (pad_in),
      .filt_en   (cfg_q[R_GFE]), // [RULE_08]
      .sync_level(sync_level),
      .level     (in_level)
   );

   wire logic [NPIN-1:0] irq_enable = cfg_q[R_IER];
   wire logic [NPIN-1:0] mlo = cfg_q[R_ML];
   wire logic [NPIN-1:0] mhi = cfg_q[R_MH];
   wire logic [NPIN-1:0] rise = in_level & ~prev_reg; // [RULE_21]
   wire logic [NPIN-1:0] fall = ~in_level & prev_reg;
   wire logic [NPIN-1:0] trig = (~mhi & ~mlo & (rise | fall)) |
                                (~mhi & mlo & rise) |
                                (mhi & ~mlo & fall); // [RULE_07] [RULE_21]
   wire logic [NPIN-1:0] evt = trig & irq_enable; // [RULE_06]
   wire logic [NPIN-1:0] clr_mask = flag_clr_wr ? bus_wdata : '0;

   // new event wins over a clear in the same cycle
   assign flags_next = (flags_reg & ~clr_mask) | evt; // [RULE_10]

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         prev_reg  <= '0;
         flags_reg <= '0;
         level_reg <= '0;
      end
      else
      begin
         prev_reg  <= in_level;
         flags_reg <= flags_next;
         level_reg <= sync_level & (gp_select | irq_enable); // [RULE_02] [RULE_03]
      end
   end

   // ************************************************************
   // pad controls
   // ************************************************************
   wire logic [NPIN-1:0] pu = cfg_q[R_PU];
   wire logic [NPIN-1:0] pd = cfg_q[R_PD];

   assign pad_next.out       = cfg_q[R_OVR]; // [RULE_01]
   assign pad_next.pull_up   = pu & ~pd; // [RULE_04] [RULE_05]
   assign pad_next.pull_down = ~pu & pd; // [RULE_05]
   assign pad_next.keeper    = pu & pd; // [RULE_05]
   assign pad_next.drive_lo  = cfg_q[R_DSL]; // [RULE_12]
   assign pad_next.drive_hi  = cfg_q[R_DSH]; // [RULE_12]

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         pad_reg <= '0;
         irq_reg <= '0;
      end
      else
      begin
         pad_reg <= pad_next;
         irq_reg <= flags_reg & irq_enable; // [RULE_11]
      end
   end

   assign pad_o   = pad_reg;
   assign pin_irq = irq_reg;

   // ************************************************************
   // read path
   // ************************************************************
   always_comb
   begin
      rd_next = '0;
      for (int i = 0; i < NREG; i++)
         if (bus_addr == REG_BASE[i])
            rd_next = cfg_q[i];
      if (bus_addr == OFS_PIN_LEVEL)
         rd_next = level_reg;
      if (bus_addr == OFS_IRQ_FLAGS)
         rd_next = flags_reg;
      if (bus_addr == OFS_LOCK)
         rd_next = lock_q;
      if (bus_addr == OFS_ACCESS_STATUS)
         rd_next[AE_BIT] = ae_reg;
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         rdata_reg <= '0;
      else
         rdata_reg <= bus_rd ? rd_next : '0;
   end

   assign bus_rdata = rdata_reg;

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   sequence s_unlock;
      bus_wr && bus_addr == OFS_UNLOCK &&
      bus_wdata[KEY_MSB:KEY_LSB] == UNLOCK_KEY &&
      bus_wdata[TGT_MSB:0] == PORT_OFFSET + 10'(OFS_LOCK);
   endsequence

   sequence s_lock_write;
      bus_wr && bus_addr == OFS_LOCK;
   endsequence

   a_out_follows_write: assert property ( // [RULE_01]
      bus_wr && bus_addr == OFS_OUTPUT_VALUE && lock_q == '0
      |=> ##1 pad_o.out == $past(bus_wdata, 2))
      else $error("pad output does not follow output value write");

   a_level_masked: assert property ( // [RULE_03]
      (level_reg & ~$past(gp_select | irq_enable)) == '0)
      else $error("pin level shown for pin without gpio or irq");

   a_level_read: assert property ( // [RULE_02]
      bus_rd && bus_addr == OFS_PIN_LEVEL |=> bus_rdata == $past(level_reg))
      else $error("pin level read does not return sampled level");

   a_flag_needs_enable: assert property ( // [RULE_06]
      (flags_reg & ~$past(flags_reg) & ~$past(irq_enable)) == '0)
      else $error("flag set on pin with interrupt disabled");

   a_reserved_silent: assert property ( // [RULE_21]
      (flags_reg & ~$past(flags_reg) & $past(mhi & mlo)) == '0)
      else $error("reserved mode raised a flag");

   a_flag_sets: assert property ( // [RULE_10]
      |evt |=> (flags_reg & $past(evt)) == $past(evt))
      else $error("detected event not flagged");

   a_flag_clears: assert property ( // [RULE_10]
      flag_clr_wr |=>
      (flags_reg & $past(bus_wdata) & ~$past(evt)) == '0)
      else $error("flag clear write left flag set");

   a_lock_holds: assert property ( // [RULE_13]
      ((cfg_q[R_OVR] ^ $past(cfg_q[R_OVR])) & $past(lock_q)) == '0 &&
      ((cfg_q[R_IER] ^ $past(cfg_q[R_IER])) & $past(lock_q)) == '0)
      else $error("locked bit changed");

   a_lock_unlocked: assert property ( // [RULE_14]
      s_unlock ##1 !bus_wr ##1 s_lock_write |=> lock_q == $past(bus_wdata))
      else $error("unlocked lock write not taken");

   a_lock_refused: assert property ( // [RULE_14]
      s_lock_write and !armed_reg |=> lock_q == $past(lock_q) && ae_reg)
      else $error("protected lock write taken without unlock");

   a_lock_set_open: assert property ( // [RULE_15]
      bus_wr && bus_addr == OFS_LOCK_SET
      |=> lock_q == ($past(lock_q) | $past(bus_wdata)))
      else $error("lock set alias not applied");

   a_error_on_lock: assert property ( // [RULE_19]
      bus_wr && bus_addr == OFS_OUTPUT_VALUE &&
      |((bus_wdata ^ cfg_q[R_OVR]) & lock_q) |=>
      ae_reg ##1 (ae_reg || $past(asr_wr)))
      else $error("access error not raised on locked write");

endmodule
`default_nettype wire

// ### verification/gpp_pad_model.sv
// pad-side model: external drivers, pulls and bus keeper on each pin
`timescale 1ns/1ps
`default_nettype none
module gpp_pad_model
   import gpp_pkg::*;
(
   // clock
   input  wire logic            mclk,
   // pad controls from the port
   input  var  gpp_pad_type     pad_o,
   // external driver
   input  wire logic [NPIN-1:0] ext_en,
   input  wire logic [NPIN-1:0] ext_val,
   // pad levels
   output logic [NPIN-1:0]      pad_in
);
   logic [NPIN-1:0] float_pin;
   logic [NPIN-1:0] lvl_next;

   // ************************************************************
   // driver wins, then pulls; keeper holds; floating pins wander
   // ************************************************************
   assign float_pin = ~ext_en
                    & ~(pad_o.pull_up | pad_o.pull_down | pad_o.keeper);
   assign lvl_next  = (ext_en & ext_val)
                    | (~ext_en & pad_o.pull_up)
                    | (~ext_en & pad_o.keeper & pad_in)
                    | (float_pin & ~pad_in);

   initial pad_in = '0;
   always @(posedge mclk) pad_in <= lvl_next;
endmodule
`default_nettype wire

// ### verification/test_gpp_port_ctrl.sv
// self-checking bench for the gpio port control block
`timescale 1ns/1ps
`default_nettype none
module test_gpp_port_ctrl;
   import gpp_pkg::*;
   localparam logic [9:0] POFS = 10'h100;
   logic            mclk;
   logic            resetn;
   logic            bus_wr;
   logic            bus_rd;
   logic [8:0]      bus_addr;
   logic [31:0]     bus_wdata;
   logic [31:0]     bus_rdata;
   logic [NPIN-1:0] pad_in;
   logic [NPIN-1:0] gp_select;
   logic [NPIN-1:0] pin_irq;
   logic [NPIN-1:0] ext_en;
   logic [NPIN-1:0] ext_val;
   gpp_pad_type     pad_o;
   int              fail_count;
   int              n_compared;
   logic [31:0]     seed;
   logic [31:0]     m [NREG];
   logic [31:0]     lk;
   logic [31:0]     rv;
   logic [31:0]     v;
   logic [31:0]     e;
   logic            ae;

   gpp_port_ctrl #(.PORT_OFFSET(POFS)) u_dut (.mclk(mclk), .resetn(resetn),
      .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
      .bus_rd(bus_rd), .bus_rdata(bus_rdata), .pad_in(pad_in),
      .gp_select(gp_select), .pad_o(pad_o), .pin_irq(pin_irq));
   gpp_pad_model u_pad (.mclk(mclk), .pad_o(pad_o), .ext_en(ext_en),
      .ext_val(ext_val), .pad_in(pad_in));

   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [31:0] apply(int op, logic [31:0] o, d, k);
      case (op)
         0:       return (o & k) | (d & ~k);
         1:       return o | (d & ~k);
         2:       return o & ~(d & ~k);
         default: return o ^ (d & ~k);
      endcase
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [8:0] a, input logic [31:0] d);
      @(posedge mclk);
      bus_wr    <= 1'b1;
      bus_addr  <= a;
      bus_wdata <= d;
      @(posedge mclk);
      bus_wr    <= 1'b0;
   endtask

   task automatic rdc(input logic [8:0] a, input logic [31:0] exp);
      @(posedge mclk);
      bus_rd   <= 1'b1;
      bus_addr <= a;
      @(posedge mclk);
      bus_rd   <= 1'b0;
      #1;
      rv = bus_rdata;
      chk(rv, exp);
   endtask

   task automatic op_reg(input int r, input int op, input logic [31:0] d);
      wr(REG_BASE[r] + 9'(op * 4), d);
      if (((apply(op, m[r], d, '0) ^ m[r]) & lk) != '0)
         ae = 1'b1;
      m[r] = apply(op, m[r], d, lk);
   endtask

   task automatic pads(input logic [31:0] en, val, gs);
      @(posedge mclk);
      ext_en    <= en;
      ext_val   <= val;
      gp_select <= gs;
      repeat (8) @(posedge mclk);
   endtask

   task automatic chk_pads();
      chk(pad_o.out, m[R_OVR]);
      chk(pad_o.pull_up, m[R_PU] & ~m[R_PD]);
      chk(pad_o.pull_down, ~m[R_PU] & m[R_PD]);
      chk(pad_o.keeper, m[R_PU] & m[R_PD]);
      chk(pad_o.drive_lo, m[R_DSL]);
      chk(pad_o.drive_hi, m[R_DSH]);
   endtask

   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // ************************************************************
   // main sequence
   // ************************************************************
   initial
   begin
      {resetn, bus_wr, bus_rd, bus_addr, bus_wdata} = '0;
      {gp_select, ext_val, lk, ae, fail_count, n_compared} = '0;
      ext_en = '1;
      seed   = 32'h0000_0018;
      foreach (m[i]) m[i] = '0;
      repeat (4) @(posedge mclk);
      resetn <= 1'b1;
      for (int r = 0; r < NREG; r++)
         rdc(REG_BASE[r], '0);
      rdc(OFS_PIN_LEVEL, '0);
      rdc(OFS_IRQ_FLAGS, '0);
      rdc(OFS_UNLOCK, '0);
      rdc(9'h1F0, '0);
      // all aliases of every lockable register, unlocked then locked
      for (int p = 0; p < 2; p++)
      begin
         if (p == 1)
         begin
            lk = rnd();
            wr(OFS_LOCK_SET, lk);
         end
         for (int r = 0; r < NREG; r++)
            for (int op = 0; op < 4; op++)
            begin
               op_reg(r, op, rnd());
               rdc(REG_BASE[r], m[r]);
            end
         chk_pads();
         rdc(OFS_LOCK, lk);
         rdc(OFS_ACCESS_STATUS, 32'(ae));
         wr(OFS_ACCESS_STATUS, '0);
         ae = 1'b0;
      end
      // protected lock aliases
      wr(OFS_LOCK, '0);
      rdc(OFS_LOCK, lk);
      wr(OFS_UNLOCK, {8'h55, 14'h0, POFS + 10'h1A8});
      wr(OFS_LOCK + 9'h008, '1);
      rdc(OFS_LOCK, lk);
      wr(OFS_UNLOCK, {UNLOCK_KEY, 14'h0, POFS + 10'h1A8});
      wr(OFS_LOCK, '0);
      rdc(OFS_LOCK, lk);
      rdc(OFS_ACCESS_STATUS, 32'h1);
      wr(OFS_ACCESS_STATUS, '0);
      rdc(OFS_ACCESS_STATUS, '0);
      wr(OFS_UNLOCK, {UNLOCK_KEY, 14'h0, POFS + 10'h1A0});
      wr(OFS_LOCK, ~lk);
      rdc(OFS_LOCK, ~lk);
      rdc(OFS_ACCESS_STATUS, '0);
      wr(OFS_UNLOCK, {UNLOCK_KEY, 14'h0, POFS + 10'h1AC});
      wr(OFS_LOCK + 9'h00C, ~lk);
      rdc(OFS_LOCK, '0);
      lk = '0;
      // pin level and pulls
      op_reg(R_IER, 0, rnd());
      v = rnd();
      pads('1, v, rnd());
      rdc(OFS_PIN_LEVEL, v & (gp_select | m[R_IER]));
      op_reg(R_PU, 0, rnd());
      op_reg(R_PD, 0, rnd());
      e = m[R_PU] | m[R_PD];
      // pulled pins released, the others still driven
      pads(~e, v, '1);
      rdc(OFS_PIN_LEVEL, (~e & v) |
          (e & m[R_PU] & (~m[R_PD] | v)));
      chk(rv & e, ((m[R_PU] & ~m[R_PD]) | (m[R_PU] & v)) & e);
      pads('1, '0, '1);
      // edge modes; filter touched only with interrupts off
      op_reg(R_IER, 0, '0);
      op_reg(R_GFE, 0, '0);
      op_reg(R_ML, 0, rnd());
      op_reg(R_MH, 0, rnd());
      wr(OFS_IRQ_FLAGS_CLR, '1);
      op_reg(R_IER, 0, rnd());
      rdc(OFS_IRQ_FLAGS, '0);
      pads('1, '1, '1);
      e = m[R_IER] & ~m[R_MH];
      rdc(OFS_IRQ_FLAGS, e);
      chk(pin_irq, e);
      op_reg(R_IER, 2, 32'h0000_FFFF);
      rdc(OFS_IRQ_FLAGS, e);
      chk(pin_irq, e & m[R_IER]);
      wr(OFS_IRQ_FLAGS_CLR, '1);
      rdc(OFS_IRQ_FLAGS, '0);
      op_reg(R_IER, 0, rnd());
      pads('1, '0, '1);
      rdc(OFS_IRQ_FLAGS, m[R_IER] & ~m[R_ML]);
      // one-cycle glitch on every pin
      op_reg(R_IER, 0, '0);
      op_reg(R_GFE, 0, rnd());
      op_reg(R_ML, 0, '0);
      op_reg(R_MH, 0, '0);
      wr(OFS_IRQ_FLAGS_CLR, '1);
      op_reg(R_IER, 0, '1);
      @(posedge mclk);
      ext_val <= '1;
      @(posedge mclk);
      ext_val <= '0;
      repeat (8) @(posedge mclk);
      rdc(OFS_IRQ_FLAGS, ~m[R_GFE]);
      final_report();
   end

   initial
   begin
      repeat (20000) @(posedge mclk);
      fail_count++;
      final_report();
   end
endmodule
`default_nettype wire
